/* pkg/param_view_consts.vh */
// Contract
// (R1) Limit 0 both, 1 no reverse, 2 no forward
// (R2) Limit gates panel, unit, terminals, communication
// (R3) Select 9999: panel and unit see simple only
// (R4) Select 0: simple and extended both visible
// (R5) Select 1: only group members readable
// (R6) Group holds at most sixteen numbers
// (R7) Count read returns entries, read only
// (R8) Count write 9999 clears, others ignored
// (R9) Register write 0 to 999 adds number
// (R10) Delete write removes number from group
// (R11) Register/delete read 9999; writing 9999 idle
// (R12) Protect, select, contrast always readable
// (R13) Numbers 77, 160, 172-174 never registered
// (R14) Option-card reads bypass the filter
// (R15) Serial bypass depends on source selections
// (R16) Fitted plug-in option parameters readable
// (R17) Unit attached: 15, 16, 991 count simple
// (R18) Full group or duplicate leaves group unchanged
`ifndef PARAM_VIEW_CONSTS_VH
`define PARAM_VIEW_CONSTS_VH
`define PV_NUM_W 10
`define PV_DATA_W 16
`define PV_GROUP_DEPTH 16
`define PV_IDX_W 4
`define PV_CNT_W 5
`define PV_CNT_FULL 5'h10
`define PV_NUM_MAX 16'h03E7
`define PV_NONE 16'h270F
// Parameter numbers
`define PN_JOG_FREQ 10'h00F
`define PN_JOG_TIME 10'h010
`define PN_WRITE_PROTECT 10'h04D
`define PN_ROT_LIMIT 10'h04E
`define PN_VIS_SELECT 10'h0A0
`define PN_GROUP_COUNT 10'h0AC
`define PN_GROUP_REG 10'h0AD
`define PN_GROUP_DEL 10'h0AE
`define PN_CONTRAST 10'h3DF
// Setting values
`define ROT_BOTH 16'h0000
`define ROT_NO_REV 16'h0001
`define ROT_NO_FWD 16'h0002
`define VIS_ALL 16'h0000
`define VIS_GROUP 16'h0001
`define VIS_SIMPLE 16'h270F
`define PANEL_SRC_PU 16'h0002
`define NET_SRC_SERIAL 16'h0001
`define NET_SRC_AUTO 16'h270F
// Access sources
`define SRC_PANEL 2'h0
`define SRC_UNIT 2'h1
`define SRC_SERIAL 2'h2
`define SRC_OPTION 2'h3
// Command source lanes: panel keys, unit keys, terminals, communication
`define CMD_LANES 4
`endif

/* design/parameter_view_filter.v */
`timescale 1ns/100ps
`include "param_view_consts.vh"
module parameter_view_filter (
    input wire clk_sys,
    input wire rst_b,
    input wire accValid,
    input wire accWrite,
    input wire [1:0] accSource,
    input wire [`PV_NUM_W-1:0] accNum,
    input wire [`PV_DATA_W-1:0] accData,
    input wire paramIsSimple,
    input wire paramIsOption,
    input wire optionFitted,
    input wire commOptionCard,
    input wire parameterUnitAttached,
    input wire [`PV_DATA_W-1:0] netCommandSourceSelect,
    input wire [`PV_DATA_W-1:0] panelCommandSourceSelect,
    input wire [`CMD_LANES-1:0] fwdCmd,
    input wire [`CMD_LANES-1:0] revCmd,
    output reg respValid_r,
    output reg respGranted_r,
    output reg respHere_r,
    output reg [`PV_DATA_W-1:0] respData_r,
    output reg [`CMD_LANES-1:0] fwdRunOk_r,
    output reg [`CMD_LANES-1:0] revRunOk_r,
    output reg [`PV_DATA_W-1:0] rotationDirectionLimit_r,
    output reg [`PV_DATA_W-1:0] readVisibilitySelect_r,
    output reg [`PV_CNT_W-1:0] groupCount_r
);

    function isAlwaysReadable;
        input [`PV_NUM_W-1:0] n;
        begin
            isAlwaysReadable = (n == `PN_WRITE_PROTECT) || (n == `PN_VIS_SELECT) ||
                               (n == `PN_CONTRAST);
        end
    endfunction

    function isBarredFromGroup;
        input [`PV_NUM_W-1:0] n;
        begin
            isBarredFromGroup = (n == `PN_WRITE_PROTECT) || (n == `PN_VIS_SELECT) ||
                                (n == `PN_GROUP_COUNT) || (n == `PN_GROUP_REG) ||
                                (n == `PN_GROUP_DEL);
        end
    endfunction

    function isOwnParam;
        input [`PV_NUM_W-1:0] n;
        begin
            isOwnParam = (n == `PN_ROT_LIMIT) || (n == `PN_VIS_SELECT) ||
                         (n == `PN_GROUP_COUNT) || (n == `PN_GROUP_REG) ||
                         (n == `PN_GROUP_DEL);
        end
    endfunction

    function isValidLimit;
        input [`PV_DATA_W-1:0] v;
        begin
            isValidLimit = (v == `ROT_BOTH) || (v == `ROT_NO_REV) || (v == `ROT_NO_FWD);
        end
    endfunction

    // Other select codes are refused so the filter never sees an undefined mode
    function isValidSelect;
        input [`PV_DATA_W-1:0] v;
        begin
            isValidSelect = (v == `VIS_ALL) || (v == `VIS_GROUP) || (v == `VIS_SIMPLE);
        end
    endfunction

    // Serial reads skip the filter only for two pairings of source selections
    function serialBypass;
        input [`PV_DATA_W-1:0] panelSel;
        input [`PV_DATA_W-1:0] netSel;
        input commCard;
        begin
            serialBypass = (panelSel == `PANEL_SRC_PU) &&
                           ((netSel == `NET_SRC_SERIAL) ||
                            ((netSel == `NET_SRC_AUTO) && !commCard));
        end
    endfunction

    reg [`PV_NUM_W-1:0] slotNum_r [0:`PV_GROUP_DEPTH-1];
    reg [`PV_GROUP_DEPTH-1:0] slotUsed_r;

    // Match on the requested read number and on the written value
    wire [`PV_NUM_W-1:0] dataNum = accData[`PV_NUM_W-1:0];
    wire dataInRange = (accData <= `PV_NUM_MAX);
    wire [`PV_GROUP_DEPTH-1:0] hitAcc;
    wire [`PV_GROUP_DEPTH-1:0] hitData;
    genvar g;
    generate
        for (g = 0; g < `PV_GROUP_DEPTH; g = g + 1) begin : gMatch
            assign hitAcc[g] = slotUsed_r[g] && (slotNum_r[g] == accNum);
            assign hitData[g] = slotUsed_r[g] && (slotNum_r[g] == dataNum);
        end
    endgenerate

    // Lowest free slot; group full shows as freeFound low
    reg freeFound;
    reg [`PV_IDX_W-1:0] freeIdx;
    integer i;
    always @* begin
        freeFound = 1'b0;
        freeIdx = {`PV_IDX_W{1'b0}};
        for (i = `PV_GROUP_DEPTH - 1; i >= 0; i = i - 1) begin
            if (!slotUsed_r[i]) begin
                freeFound = 1'b1;
                freeIdx = i[`PV_IDX_W-1:0];
            end
        end
    end

    // Filter bypass decision per source
    reg bypass;
    always @* begin
        case (accSource)
            `SRC_OPTION: bypass = 1'b1; // R14
            `SRC_SERIAL: begin
                bypass = serialBypass(panelCommandSourceSelect, netCommandSourceSelect,
                                      commOptionCard); // R15
            end
            default: bypass = 1'b0;
        endcase
    end

    // Unit attached promotes jog and contrast to simple
    wire simpleEff = paramIsSimple || (parameterUnitAttached &&
                     ((accNum == `PN_JOG_FREQ) || (accNum == `PN_JOG_TIME) ||
                      (accNum == `PN_CONTRAST))); // R17
    // Option parameters exist only with the option fitted
    wire existsHere = !paramIsOption || optionFitted; // R16

    reg readOk;
    always @* begin
        if (!existsHere) begin
            readOk = 1'b0;
        end else if (bypass || isAlwaysReadable(accNum)) begin // R12
            readOk = 1'b1;
        end else begin
            case (readVisibilitySelect_r)
                `VIS_SIMPLE: readOk = simpleEff || paramIsOption; // R3
                `VIS_GROUP: readOk = |hitAcc; // R5
                default: readOk = 1'b1; // R4
            endcase
        end
    end

    reg [`PV_DATA_W-1:0] ownData;
    always @* begin
        case (accNum)
            `PN_ROT_LIMIT: ownData = rotationDirectionLimit_r;
            `PN_VIS_SELECT: ownData = readVisibilitySelect_r;
            `PN_GROUP_COUNT: ownData = {{(`PV_DATA_W-`PV_CNT_W){1'b0}}, groupCount_r}; // R7
            `PN_GROUP_REG: ownData = `PV_NONE; // R11
            `PN_GROUP_DEL: ownData = `PV_NONE; // R11
            default: ownData = {`PV_DATA_W{1'b0}};
        endcase
    end

    // Write decoding
    wire wrStrobe = accValid && accWrite;
    wire wrLimit = wrStrobe && (accNum == `PN_ROT_LIMIT) && isValidLimit(accData); // R1
    wire wrVis = wrStrobe && (accNum == `PN_VIS_SELECT) && isValidSelect(accData);
    wire wrClear = wrStrobe && (accNum == `PN_GROUP_COUNT) && (accData == `PV_NONE); // R8
    // Each refusal reason kept apart; any one of them leaves the group as it was
    wire addBarred = isBarredFromGroup(dataNum); // R13
    wire addDuplicate = |hitData; // R18
    wire addRoom = freeFound; // R6
    wire wrAdd = wrStrobe && (accNum == `PN_GROUP_REG) && dataInRange &&
                 !addBarred && !addDuplicate && addRoom; // R9 R18
    wire wrDel = wrStrobe && (accNum == `PN_GROUP_DEL) && dataInRange &&
                 (|hitData); // R10
    // 9999 to register or delete is accepted but idle
    wire wrIdle = wrStrobe && ((accNum == `PN_GROUP_REG) || (accNum == `PN_GROUP_DEL)) &&
                  (accData == `PV_NONE); // R11
    wire wrOk = wrLimit || wrVis || wrClear || wrAdd || wrDel || wrIdle;

    reg [`PV_DATA_W-1:0] rotationDirectionLimit_nxt;
    reg [`PV_DATA_W-1:0] readVisibilitySelect_nxt;
    always @* begin
        rotationDirectionLimit_nxt = rotationDirectionLimit_r;
        readVisibilitySelect_nxt = readVisibilitySelect_r;
        if (wrLimit) begin
            rotationDirectionLimit_nxt = accData; // R1
        end
        if (wrVis) begin
            readVisibilitySelect_nxt = accData;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rotationDirectionLimit_r <= `ROT_BOTH; // R1
            readVisibilitySelect_r <= `VIS_ALL; // R4
        end else begin
            rotationDirectionLimit_r <= rotationDirectionLimit_nxt;
            readVisibilitySelect_r <= readVisibilitySelect_nxt;
        end
    end

    // One-hot load of the chosen free slot
    wire [`PV_GROUP_DEPTH-1:0] slotLoad;
    generate
        for (g = 0; g < `PV_GROUP_DEPTH; g = g + 1) begin : gLoad
            assign slotLoad[g] = wrAdd && (freeIdx == g);
        end
    endgenerate

    // Deletes leave holes; registration reuses the lowest hole
    reg [`PV_GROUP_DEPTH-1:0] slotUsed_nxt;
    reg [`PV_CNT_W-1:0] groupCount_nxt;
    always @* begin
        slotUsed_nxt = slotUsed_r;
        groupCount_nxt = groupCount_r;
        if (wrClear) begin
            slotUsed_nxt = {`PV_GROUP_DEPTH{1'b0}}; // R8
            groupCount_nxt = {`PV_CNT_W{1'b0}};
        end else if (wrAdd) begin
            slotUsed_nxt = slotUsed_r | slotLoad; // R9
            groupCount_nxt = groupCount_r + 1'b1; // R7
        end else if (wrDel) begin
            slotUsed_nxt = slotUsed_r & ~hitData; // R10
            groupCount_nxt = groupCount_r - 1'b1;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            slotUsed_r <= {`PV_GROUP_DEPTH{1'b0}};
            groupCount_r <= {`PV_CNT_W{1'b0}};
        end else begin
            slotUsed_r <= slotUsed_nxt;
            groupCount_r <= groupCount_nxt;
        end
    end

    generate
        for (g = 0; g < `PV_GROUP_DEPTH; g = g + 1) begin : gSlot
            always @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    slotNum_r[g] <= {`PV_NUM_W{1'b0}};
                end else if (slotLoad[g]) begin
                    slotNum_r[g] <= dataNum;
                end
            end
        end
    endgenerate

    // Granted, here and data fields hold their last value between requests
    reg respGranted_nxt;
    reg respHere_nxt;
    reg [`PV_DATA_W-1:0] respData_nxt;
    always @* begin
        respGranted_nxt = respGranted_r;
        respHere_nxt = respHere_r;
        respData_nxt = respData_r;
        if (accValid) begin
            respHere_nxt = isOwnParam(accNum);
            if (accWrite) begin
                respGranted_nxt = wrOk;
                respData_nxt = {`PV_DATA_W{1'b0}};
            end else begin
                respGranted_nxt = readOk;
                // Only parameters held here have data to return
                respData_nxt = (readOk && respHere_nxt) ? ownData : {`PV_DATA_W{1'b0}};
            end
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            respValid_r <= 1'b0;
            respGranted_r <= 1'b0;
            respHere_r <= 1'b0;
            respData_r <= {`PV_DATA_W{1'b0}};
        end else begin
            respValid_r <= accValid;
            respGranted_r <= respGranted_nxt;
            respHere_r <= respHere_nxt;
            respData_r <= respData_nxt;
        end
    end

    // Same limit applies to every command lane, whatever its source
    wire fwdBlocked = (rotationDirectionLimit_r == `ROT_NO_FWD); // R1
    wire revBlocked = (rotationDirectionLimit_r == `ROT_NO_REV); // R1
    wire [`CMD_LANES-1:0] fwdRunOk_nxt;
    wire [`CMD_LANES-1:0] revRunOk_nxt;
    generate
        for (g = 0; g < `CMD_LANES; g = g + 1) begin : gLane
            assign fwdRunOk_nxt[g] = fwdCmd[g] && !fwdBlocked; // R2
            assign revRunOk_nxt[g] = revCmd[g] && !revBlocked; // R2
        end
    endgenerate

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fwdRunOk_r <= {`CMD_LANES{1'b0}};
            revRunOk_r <= {`CMD_LANES{1'b0}};
        end else begin
            fwdRunOk_r <= fwdRunOk_nxt;
            revRunOk_r <= revRunOk_nxt;
        end
    end

endmodule

/* dv/host_lookup_model.sv */
`timescale 1ns/100ps
module host_lookup_model (
    input wire logic [9:0] accNum,
    output logic paramIsSimple,
    output logic paramIsOption
);
    // Jog pair left out so it only shows as simple with the unit fitted
    assign paramIsSimple = accNum < 10'h064 && accNum != 10'h00F && accNum != 10'h010;
    assign paramIsOption = accNum >= 10'h384 && accNum != 10'h3DF;
endmodule

/* dv/parameter_view_filter_sva.sv */
`timescale 1ns/100ps
module parameter_view_filter_sva (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic accValid,
    input wire logic accWrite,
    input wire logic [1:0] accSource,
    input wire logic [9:0] accNum,
    input wire logic [15:0] accData,
    input wire logic paramIsOption,
    input wire logic [3:0] fwdCmd,
    input wire logic respGranted_r,
    input wire logic [15:0] respData_r,
    input wire logic [3:0] fwdRunOk_r,
    input wire logic [3:0] revRunOk_r,
    input wire logic [15:0] rotationDirectionLimit_r,
    input wire logic [15:0] readVisibilitySelect_r,
    input wire logic [4:0] groupCount_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire wrReq = accValid && accWrite;
    wire rdReq = accValid && !accWrite;
    a_fwd_block: assert property (rotationDirectionLimit_r == 16'h0002 |=> fwdRunOk_r == 4'h0)
        else $error("forward lane passed while blocked");
    a_rev_block: assert property (rotationDirectionLimit_r == 16'h0001 |=> revRunOk_r == 4'h0)
        else $error("reverse lane passed while blocked");
    a_fwd_pass: assert property (rotationDirectionLimit_r != 16'h0002 |=> fwdRunOk_r == $past(fwdCmd))
        else $error("forward lanes not passed through");
    a_count_max: assert property (groupCount_r <= 5'h10)
        else $error("group count above sixteen");
    a_count_clear: assert property (wrReq && accNum == 10'h0AC && accData == 16'h270F
        && readVisibilitySelect_r == 16'h0000 |=> groupCount_r == 5'h00)
        else $error("batch clear did not empty group");
    a_clear_ignored: assert property (wrReq && accNum == 10'h0AC && accData != 16'h270F
        |=> $stable(groupCount_r))
        else $error("count write changed group");
    a_reg_step: assert property (wrReq && accNum == 10'h0AD
        |=> groupCount_r <= $past(groupCount_r) + 5'h01)
        else $error("registration grew group by more than one");
    a_bar_reg: assert property (wrReq && accNum == 10'h0AD && (accData == 16'h004D
        || accData == 16'h00A0 || (accData >= 16'h00AC && accData <= 16'h00AE))
        |=> !respGranted_r && $stable(groupCount_r))
        else $error("barred number registered");
    a_entry_read: assert property (rdReq && (accNum == 10'h0AD || accNum == 10'h0AE)
        |=> !respGranted_r || respData_r == 16'h270F)
        else $error("entry read not 9999");
    a_option_path: assert property (rdReq && accSource == 2'h3 && !paramIsOption
        |=> respGranted_r)
        else $error("option card read refused");
    a_fixed_read: assert property (rdReq && accSource < 2'h2 && !paramIsOption && (accNum == 10'h04D
        || accNum == 10'h0A0 || accNum == 10'h3DF) |=> respGranted_r)
        else $error("always readable parameter refused");
endmodule
bind parameter_view_filter parameter_view_filter_sva parameter_view_filter_sva_inst (.clk_sys,
    .rst_b, .accValid, .accWrite, .accSource, .accNum, .accData, .paramIsOption, .fwdCmd,
    .respGranted_r, .respData_r, .fwdRunOk_r, .revRunOk_r, .rotationDirectionLimit_r,
    .readVisibilitySelect_r, .groupCount_r);

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic clk_sys, rst_b, accValid, accWrite, paramIsSimple, paramIsOption, optionFitted;
    logic commOptionCard, parameterUnitAttached, respValid_r, respGranted_r, respHere_r;
    logic [1:0] accSource;
    logic [9:0] accNum;
    logic [15:0] accData, netCommandSourceSelect, panelCommandSourceSelect, respData_r;
    logic [15:0] rotationDirectionLimit_r, readVisibilitySelect_r;
    logic [3:0] fwdCmd, revCmd, fwdRunOk_r, revRunOk_r;
    logic [4:0] groupCount_r;
    int nErrors = 0;
    int checkCount = 0;
    logic [15:0] barred [5] = '{16'h004D, 16'h00A0, 16'h00AC, 16'h00AD, 16'h00AE};
    host_lookup_model host_lookup_model_inst (.accNum, .paramIsSimple, .paramIsOption);
    parameter_view_filter parameter_view_filter_inst (.clk_sys, .rst_b, .accValid, .accWrite,
        .accSource, .accNum, .accData, .paramIsSimple, .paramIsOption, .optionFitted,
        .commOptionCard, .parameterUnitAttached, .netCommandSourceSelect,
        .panelCommandSourceSelect, .fwdCmd, .revCmd, .respValid_r, .respGranted_r,
        .respHere_r, .respData_r, .fwdRunOk_r, .revRunOk_r, .rotationDirectionLimit_r,
        .readVisibilitySelect_r, .groupCount_r);
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] s, input logic [9:0] n,
        input logic [15:0] d, input logic g, input logic [15:0] e);
        logic own;
        @(negedge clk_sys);
        {accValid, accWrite, accSource, accNum, accData} = {1'b1, w, s, n, d};
        @(negedge clk_sys);
        accValid = 1'b0;
        chk("valid", 16'h0001, {15'h0, respValid_r});
        chk("grant", {15'h0, g}, {15'h0, respGranted_r});
        chk("data", e, respData_r);
        own = n inside {10'h04E, 10'h0A0, 10'h0AC, 10'h0AD, 10'h0AE};
        chk("here", {15'h0, own}, {15'h0, respHere_r});
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #1000000;
        nErrors++;
        complete_run();
    end
    initial begin
        {rst_b, accValid, accWrite, accSource, accNum, accData} = '0;
        {optionFitted, commOptionCard, parameterUnitAttached, fwdCmd, revCmd} = '0;
        netCommandSourceSelect = 16'h0000;
        panelCommandSourceSelect = 16'h0001;
        repeat (5) @(negedge clk_sys);
        rst_b = 1'b1;
        chk("limit", 16'h0000, rotationDirectionLimit_r);
        chk("select", 16'h0000, readVisibilitySelect_r);
        chk("count", 16'h0000, {11'h0, groupCount_r});
        for (int v = 0; v < 3; v++) begin
            acc(1, 0, 10'h04E, 16'(v), 1, 0);
            {fwdCmd, revCmd} = 8'hFF;
            @(negedge clk_sys);
            chk("fwd", v == 2 ? 16'h0000 : 16'h000F, {12'h0, fwdRunOk_r});
            chk("rev", v == 1 ? 16'h0000 : 16'h000F, {12'h0, revRunOk_r});
        end
        acc(1, 0, 10'h04E, 16'h0003, 0, 0);
        chk("limit", 16'h0002, rotationDirectionLimit_r);
        $display("test rotation done");
        acc(1, 0, 10'h0AD, 16'h0003, 1, 0);
        acc(1, 0, 10'h0AD, 16'h0003, 0, 0);
        acc(1, 0, 10'h0AD, 16'h03E8, 0, 0);
        foreach (barred[i]) acc(1, 0, 10'h0AD, barred[i], 0, 0);
        for (int i = 0; i < 15; i++) acc(1, 0, 10'h0AD, 16'(10 + i), 1, 0);
        acc(1, 0, 10'h0AD, 16'h0020, 0, 0);
        acc(0, 0, 10'h0AC, 0, 1, 16'h0010);
        acc(0, 0, 10'h0AD, 0, 1, 16'h270F);
        acc(0, 0, 10'h0AE, 0, 1, 16'h270F);
        acc(1, 0, 10'h0AD, 16'h270F, 1, 0);
        chk("count", 16'h0010, {11'h0, groupCount_r});
        $display("test group fill done");
        acc(1, 0, 10'h0A0, 16'h0001, 1, 0);
        acc(0, 0, 10'h003, 0, 1, 0);
        acc(0, 0, 10'h1F4, 0, 0, 0);
        acc(0, 1, 10'h3DF, 0, 1, 0);
        acc(0, 0, 10'h04D, 0, 1, 0);
        acc(0, 0, 10'h0A0, 0, 1, 16'h0001);
        acc(0, 3, 10'h1F4, 0, 1, 0);
        acc(0, 2, 10'h1F4, 0, 0, 0);
        panelCommandSourceSelect = 16'h0002;
        netCommandSourceSelect = 16'h0001;
        acc(0, 2, 10'h1F4, 0, 1, 0);
        netCommandSourceSelect = 16'h270F;
        acc(0, 2, 10'h1F4, 0, 1, 0);
        commOptionCard = 1'b1;
        acc(0, 2, 10'h1F4, 0, 0, 0);
        acc(1, 0, 10'h0AE, 16'h0003, 1, 0);
        acc(0, 0, 10'h003, 0, 0, 0);
        acc(1, 0, 10'h0AE, 16'h0003, 0, 0);
        $display("test user group filter done");
        acc(1, 0, 10'h0A0, 16'h0000, 1, 0);
        acc(0, 0, 10'h1F4, 0, 1, 0);
        acc(1, 0, 10'h0AC, 16'h0005, 0, 0);
        chk("count", 16'h000F, {11'h0, groupCount_r});
        acc(1, 0, 10'h0AC, 16'h270F, 1, 0);
        chk("count", 16'h0000, {11'h0, groupCount_r});
        acc(1, 0, 10'h0A0, 16'h270F, 1, 0);
        acc(0, 0, 10'h005, 0, 1, 0);
        acc(0, 0, 10'h1F4, 0, 0, 0);
        acc(0, 1, 10'h00F, 0, 0, 0);
        parameterUnitAttached = 1'b1;
        acc(0, 1, 10'h00F, 0, 1, 0);
        acc(0, 1, 10'h010, 0, 1, 0);
        acc(0, 0, 10'h384, 0, 0, 0);
        optionFitted = 1'b1;
        acc(0, 0, 10'h384, 0, 1, 0);
        $display("test simple view done");
        acc(1, 0, 10'h0AD, 16'h0007, 1, 0);
        rst_b = 1'b0;
        @(negedge clk_sys);
        rst_b = 1'b1;
        chk("limit", 16'h0000, rotationDirectionLimit_r);
        chk("count", 16'h0000, {11'h0, groupCount_r});
        acc(0, 0, 10'h0A0, 0, 1, 16'h0000);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
